// ==== stage_seq_map.svh ====
// Register offsets, field positions, reset values and timing counts of the stage sequencer.
`ifndef STAGE_SEQ_MAP_SVH
`define STAGE_SEQ_MAP_SVH

`define CTRL_OFS         8'h00
`define STATUS_OFS       8'h04
`define THRESH_OFS       8'h08
`define BUTTON_OFS       8'h0C
`define REGION_MISC      2'h0
`define REGION_ROUTE     2'h1
`define REGION_OFFSET    2'h2
`define REGION_RESULT    2'h3

`define PMODE_LSB        0
`define SLEEP_LSB        2
`define DECIM_LSB        8
`define LAST_LSB         12
`define POS_CODE_LSB     0
`define POS_STEER_BIT    7
`define NEG_CODE_LSB     8
`define NEG_STEER_BIT    15

`define THRESH_RST       16'h0400
`define RESULT_CENTER    17'h08000
`define STAGE_COUNT      4'hC
`define STAGE_MAX        4'hB

`define ROUTE_FLOAT      2'h0
`define ROUTE_POS        2'h1
`define ROUTE_NEG        2'h2
`define ROUTE_SHIELD     2'h3

`define CLK_HZ           20000000
`define SAMPLE_RATE_HZ   250000
`define SAMPLE_CYC       (`CLK_HZ / `SAMPLE_RATE_HZ)
`define SAMPLES_PER_OSR  3
`define OSR_LOW          128
`define OSR_HIGH         256
`define SCALE_LOW        8'hAA
`define SCALE_HIGH       8'h55
`define SLEEP_STEP_MS    200
`define SLEEP_STEP_CYC   (`SLEEP_STEP_MS * (`CLK_HZ / 1000))

`endif

// ==== stage_seq_pkg.sv ====
// Types shared by the capacitance stage sequencer.
package stage_seq_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_SLEEP
    } seq_state_t;

    typedef struct packed {
        logic [1:0]         pmode;
        logic [1:0]         sleep_sel;
        logic [1:0]         decim;
        logic [3:0]         last;
        logic [15:0]        thresh;
        logic [11:0][27:0]  route;
        logic [11:0][15:0]  offs;
        logic [11:0][15:0]  res;
        logic [11:0][1:0]   btn;
        seq_state_t         state;
        logic [3:0]         stage;
        logic [6:0]         div;
        logic [9:0]         nsamp;
        logic [9:0]         ones;
        logic [25:0]        sleep_cnt;
        logic [27:0]        route_out;
        logic [15:0]        offs_out;
        logic               conv;
        logic [31:0]        dat;
        logic               ack;
    } seq_regs_t;

endpackage : stage_seq_pkg

// ==== capacitance_stage_sequencer.sv ====
// Stage sequencer for a capacitance converter with a classic Wishbone register slave.
`timescale 1ns/100ps
`include "stage_seq_map.svh"

module capacitance_stage_sequencer #(
    parameter int SLEEP_STEP_CYC = `SLEEP_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        modulator_bit,
    output logic      [27:0] input_route_select,
    output logic      [6:0]  positive_offset_code,
    output logic             positive_offset_to_neg,
    output logic      [6:0]  negative_offset_code,
    output logic             negative_offset_to_pos,
    output logic             converting,
    output logic      [3:0]  stage_index
);

    stage_seq_pkg::seq_regs_t q;
    stage_seq_pkg::seq_regs_t s;

    logic        req;
    logic        wr;
    logic        tick;
    logic        stage_end;
    logic [3:0]  idx;
    logic [1:0]  region;
    logic [31:0] merged;
    logic [31:0] rd;
    logic [9:0]  ones_now;

    // Byte-lane merge of a Wishbone write into the old register value.
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : wb_merge

    // Samples per stage: three times the oversampling ratio.
    function automatic logic [9:0] samples_needed(input logic [1:0] decim);
        if (decim == 2'h1) begin
            return 10'(`SAMPLES_PER_OSR * `OSR_LOW);
        end
        return 10'(`SAMPLES_PER_OSR * `OSR_HIGH);
    endfunction : samples_needed

    // Averages the ones count of a stage to full 16-bit scale.
    function automatic logic [15:0] average_of(input logic [9:0] ones,
                                               input logic [1:0] decim);
        logic [17:0] p;
        p = {8'h00, ones} * {10'h000, (decim == 2'h1) ? `SCALE_LOW : `SCALE_HIGH};
        return p[15:0];
    endfunction : average_of

    // Splits a result around mid-scale into the two buttons of a pair.
    function automatic logic [1:0] pair_of(input logic [15:0] res,
                                           input logic [15:0] thr);
        logic hi;
        logic lo;
        hi = {1'b0, res} > (`RESULT_CENTER + {1'b0, thr});
        lo = {1'b0, res} + {1'b0, thr} < `RESULT_CENTER;
        // Both pressed cancel toward mid-scale, so neither side is reported.
        return (hi && !lo) ? 2'h2 : ((lo && !hi) ? 2'h1 : 2'h0);
    endfunction : pair_of

    // True when any stage inside the programmed sequence reports a button.
    function automatic logic touched_in(input logic [11:0][1:0] btn,
                                        input logic [3:0]       last);
        logic t;
        t = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (4'(i) <= last) begin
                t = t | (|btn[i]);
            end
        end
        return t;
    endfunction : touched_in

    // A request is taken only while ack is low, so a strobe still held in its ack cycle is not taken again.
    assign req       = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr        = req && wb_we_i;
    assign idx       = wb_adr_i[5:2];
    assign region    = wb_adr_i[7:6];
    // The divider free-runs, so the first sample of a stage may come up to 79 clocks in.
    assign tick      = q.div == 7'(`SAMPLE_CYC - 1);
    assign ones_now  = q.ones + {9'h000, modulator_bit};
    assign stage_end = q.state == stage_seq_pkg::SEQ_CONVERT && tick
                       && q.nsamp == samples_needed(q.decim) - 10'h001;

    always_comb begin
        s      = q;
        merged = 32'h0000_0000;
        rd     = 32'h0000_0000;
        s.ack  = req;

        unique case (region)
            `REGION_MISC: begin
                unique case ({2'h0, wb_adr_i[5:2], 2'h0})
                    `CTRL_OFS: rd = {16'h0000, q.last, 2'h0, q.decim, 4'h0,
                                     q.sleep_sel, q.pmode};
                    `STATUS_OFS: rd = {25'h0, |q.btn, q.state, q.stage};
                    `THRESH_OFS: rd = {16'h0000, q.thresh};
                    `BUTTON_OFS: rd = {8'h00, q.btn};
                    default: rd = 32'h0000_0000;
                endcase
            end
            `REGION_ROUTE: rd = (idx < `STAGE_COUNT) ? {4'h0, q.route[idx]} : 32'h0;
            `REGION_OFFSET: rd = (idx < `STAGE_COUNT) ? {16'h0000, q.offs[idx]} : 32'h0;
            `REGION_RESULT: rd = (idx < `STAGE_COUNT) ? {16'h0000, q.res[idx]} : 32'h0;
        endcase
        if (req && !wb_we_i) begin
            s.dat = rd;
        end

        if (wr) begin
            merged = wb_merge(rd, wb_dat_i, wb_sel_i);
            if (region == `REGION_MISC && wb_adr_i[5:2] == 4'h0) begin
                s.pmode     = merged[`PMODE_LSB +: 2];
                s.sleep_sel = merged[`SLEEP_LSB +: 2];
                if (!merged[`DECIM_LSB + 1]) begin
                    s.decim = merged[`DECIM_LSB +: 2];
                end
                s.last = (merged[`LAST_LSB +: 4] > `STAGE_MAX) ? `STAGE_MAX
                                                                : merged[`LAST_LSB +: 4];
            end
            if (region == `REGION_MISC && wb_adr_i[5:2] == 4'h2) begin
                s.thresh = merged[15:0];
            end
            if (region == `REGION_ROUTE && idx < `STAGE_COUNT) begin
                s.route[idx] = merged[27:0];
            end
            if (region == `REGION_OFFSET && idx < `STAGE_COUNT) begin
                s.offs[idx] = merged[15:0];
            end
        end

        s.div = tick ? 7'h00 : q.div + 7'h01;

        unique case (q.state)
            stage_seq_pkg::SEQ_IDLE: begin
                s.state = stage_seq_pkg::SEQ_CONVERT;
                s.stage = 4'h0;
                s.nsamp = 10'h000;
                s.ones  = 10'h000;
            end
            stage_seq_pkg::SEQ_CONVERT: begin
                if (tick) begin
                    s.nsamp = q.nsamp + 10'h001;
                    s.ones  = ones_now;
                end
                if (stage_end) begin
                    s.res[q.stage] = average_of(ones_now, q.decim);
                    s.btn[q.stage] = pair_of(s.res[q.stage], q.thresh);
                    s.nsamp        = 10'h000;
                    s.ones         = 10'h000;
                    if (q.stage >= q.last) begin
                        s.stage = 4'h0;
                        // Stale buttons of stages outside the sequence must not keep it awake.
                        if (q.pmode == 2'h2 && !touched_in(s.btn, q.last)) begin
                            s.state     = stage_seq_pkg::SEQ_SLEEP;
                            s.sleep_cnt = 26'(SLEEP_STEP_CYC * (int'(q.sleep_sel) + 1) - 1);
                        end
                    end else begin
                        s.stage = q.stage + 4'h1;
                    end
                end
            end
            stage_seq_pkg::SEQ_SLEEP: begin
                if (q.sleep_cnt == 26'h0) begin
                    s.state = stage_seq_pkg::SEQ_CONVERT;
                end else begin
                    s.sleep_cnt = q.sleep_cnt - 26'h1;
                end
            end
            default: s.state = stage_seq_pkg::SEQ_IDLE;
        endcase

        // Shutdown wins over everything and abandons a stage in progress.
        if (s.pmode[0]) begin
            s.state = stage_seq_pkg::SEQ_IDLE;
            s.stage = 4'h0;
            s.nsamp = 10'h000;
            s.ones  = 10'h000;
        end
        // Full power never sleeps, even when the mode changes mid-wait.
        if (s.pmode == 2'h0 && s.state == stage_seq_pkg::SEQ_SLEEP) begin
            s.state = stage_seq_pkg::SEQ_CONVERT;
        end

        // A new oversampling ratio restarts the stage so its sample count stays in range.
        if (s.decim != q.decim) begin
            s.nsamp = 10'h000;
            s.ones  = 10'h000;
        end

        s.route_out = s.route[s.stage];
        s.offs_out  = s.offs[s.stage];
        s.conv      = s.state == stage_seq_pkg::SEQ_CONVERT;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q        <= '0;
            q.thresh <= `THRESH_RST;
        end else begin
            q <= s;
        end
    end

    assign wb_dat_o               = q.dat;
    assign wb_ack_o               = q.ack;
    assign input_route_select     = q.route_out;
    assign positive_offset_code   = q.offs_out[`POS_CODE_LSB +: 7];
    assign positive_offset_to_neg = q.offs_out[`POS_STEER_BIT];
    assign negative_offset_code   = q.offs_out[`NEG_CODE_LSB +: 7];
    assign negative_offset_to_pos = q.offs_out[`NEG_STEER_BIT];
    assign converting             = q.conv;
    assign stage_index            = q.stage;

    // All checks run on the block clock and stand down while reset is held.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_stage_bound: assert property (stage_index <= `STAGE_MAX)
        else $error("stage index above eleven");

    chk_stage_within_last: assert property (converting |-> stage_index <= q.last)
        else $error("stage beyond last stage index");

    chk_route_follows_stage: assert property (
        converting && $stable(stage_index) && !$past(wr)
        |-> input_route_select == q.route[stage_index])
        else $error("routing differs from current stage configuration");

    chk_full_power_wrap: assert property (
        stage_end && q.stage >= q.last && q.pmode == 2'h0
        |=> converting && stage_index == 4'h0)
        else $error("full power sequence did not restart at first stage");

    chk_stage_advance: assert property (
        stage_end && q.stage < q.last && !q.pmode[0] |=> stage_index == $past(q.stage) + 4'h1)
        else $error("sequencer skipped a stage");

    chk_shutdown_idle: assert property (
        q.pmode[0] |-> !converting && stage_index == 4'h0)
        else $error("converting while shut down");

    chk_decim_valid: assert property (!q.decim[1])
        else $error("invalid oversampling code accepted");

    chk_sample_count: assert property (
        converting |-> q.nsamp < samples_needed(q.decim))
        else $error("stage ran past its sample count");

    chk_sample_spacing: assert property (tick |=> !tick [*8])
        else $error("modulator samples too close together");

    chk_pair_exclusive: assert property (
        stage_end |=> q.btn[$past(q.stage)] != 2'h3)
        else $error("both buttons of a pair reported");

    chk_low_power_sleep: assert property (
        stage_end && q.stage >= q.last && q.pmode == 2'h2
        && !touched_in(q.btn & ~(24'h000003 << (2 * q.stage)), q.last)
        && pair_of(average_of(ones_now, q.decim), q.thresh) == 2'h0
        |=> q.state == stage_seq_pkg::SEQ_SLEEP
            && q.sleep_cnt == 26'(SLEEP_STEP_CYC * (int'($past(q.sleep_sel)) + 1) - 1))
        else $error("low power sleep interval not loaded");

    chk_full_power_awake: assert property (
        q.pmode == 2'h0 |-> q.state != stage_seq_pkg::SEQ_SLEEP)
        else $error("full power sequencer asleep");

    chk_first_stage_start: assert property (
        $rose(converting) |-> stage_index == 4'h0)
        else $error("sequence started away from the first stage");

    chk_stage_hold: assert property (
        converting && !stage_end && !wr |=> $stable(stage_index))
        else $error("stage index moved inside a stage");

    chk_offset_follows_stage: assert property (
        converting && $stable(stage_index) && !$past(wr)
        |-> {negative_offset_to_pos, negative_offset_code,
             positive_offset_to_neg, positive_offset_code} == q.offs[stage_index])
        else $error("offset codes differ from current stage configuration");

    chk_result_full_scale: assert property (
        stage_end |=> q.res[$past(q.stage)] <= 16'hFF00)
        else $error("stage result above full scale");

    chk_decim_kept: assert property (
        wr && region == `REGION_MISC && wb_adr_i[5:2] == 4'h0 && wb_sel_i[1] && wb_dat_i[9]
        |=> q.decim == $past(q.decim))
        else $error("invalid oversampling code changed the ratio");

    chk_sleep_countdown: assert property (
        q.state == stage_seq_pkg::SEQ_SLEEP && q.sleep_cnt != 26'h0
        |=> q.sleep_cnt == $past(q.sleep_cnt) - 26'h1)
        else $error("sleep interval not counting down");

    chk_sleep_wake: assert property (
        q.state == stage_seq_pkg::SEQ_SLEEP && q.sleep_cnt == 26'h0 && !wr
        |=> converting && stage_index == 4'h0)
        else $error("sequencer did not wake at the end of the sleep interval");

    chk_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered in the next cycle");

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : capacitance_stage_sequencer

// ==== electrode_model.sv ====
// Behavioural sensor board with the modulator bit stream that it produces.
`timescale 1ns/100ps

module electrode_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [27:0] route,
    input  wire logic [13:0] touch,
    output logic             modulator_bit
);
    logic [6:0] cnt_ff;
    logic       phase_ff;
    logic       pos_hit;
    logic       neg_hit;

    // An untouched board gives a balanced stream that flips once per sample period.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff   <= 7'h00;
            phase_ff <= 1'b0;
        end else if (cnt_ff == 7'h4F) begin
            cnt_ff   <= 7'h00;
            phase_ff <= ~phase_ff;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end

    // A touched pin on the positive input pulls the stream low, on the negative one high.
    always_comb begin
        pos_hit = 1'b0;
        neg_hit = 1'b0;
        for (int i = 0; i < 14; i++) begin
            pos_hit = pos_hit | (touch[i] && route[2*i +: 2] == 2'h1);
            neg_hit = neg_hit | (touch[i] && route[2*i +: 2] == 2'h2);
        end
        modulator_bit = pos_hit ? 1'b0 : (neg_hit ? 1'b1 : phase_ff);
    end
endmodule : electrode_model

// ==== tb_top.sv ====
// Self-checking bench for the capacitance stage sequencer.
`timescale 1ns/100ps

module tb_top;
    localparam int STEP  = 200;
    localparam int LIMIT = 100000;

    logic        clk;
    logic        sys_rst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic        wb_ack;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic [31:0] rd;
    logic        mod_bit;
    logic [27:0] route;
    logic [6:0]  pcode;
    logic [6:0]  ncode;
    logic        psteer;
    logic        nsteer;
    logic        conv;
    logic [3:0]  stage;
    logic [13:0] touch;
    int          failures;
    int          checks;
    int          cycles;
    int          n;
    int          t0;

    capacitance_stage_sequencer #(.SLEEP_STEP_CYC(STEP)) i_capacitance_stage_sequencer (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .modulator_bit(mod_bit),
        .input_route_select(route), .positive_offset_code(pcode),
        .positive_offset_to_neg(psteer), .negative_offset_code(ncode),
        .negative_offset_to_pos(nsteer), .converting(conv), .stage_index(stage));

    electrode_model i_electrode_model (
        .clk(clk), .sys_rst(sys_rst), .route(route), .touch(touch), .modulator_bit(mod_bit));

    always #25 clk = ~clk;

    task summarize;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; the request stands until ack is seen at a rising edge.
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= dat;
        wb_sel  <= 4'hF;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            summarize;
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_wdat = 32'h0;
        touch = 14'h0000;
        failures = 0;
        checks = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0400);
        wb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        $display("test reset_values done");
        wb(1'b1, 8'h00, 32'h0000F201);
        wb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0000B001);
        check(conv, 1'b0);
        check(stage, 4'h0);
        wb(1'b1, 8'h70, 32'hFFFFFFFF);
        wb(1'b0, 8'h70, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, 8'hC0, 32'h0000FFFF);
        wb(1'b0, 8'hC0, 32'h0);
        check(rd, 32'h0);
        $display("test refusals done");
        // Unused pins go to the shield drive in both stages.
        wb(1'b1, 8'h40, 32'h0FFFFFFD);
        wb(1'b1, 8'h44, 32'h0FFFFFFE);
        wb(1'b1, 8'h80, 32'h00000A85);
        wb(1'b1, 8'h84, 32'h0000937F);
        wb(1'b0, 8'h44, 32'h0);
        check(rd, 32'h0FFFFFFE);
        // The sequence uses stages 0 and 1 only.
        wb(1'b1, 8'h00, 32'h00001101);
        wb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h00001101);
        touch <= 14'h0001;
        wb(1'b1, 8'h00, 32'h00001100);
        while (conv !== 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
        check(stage, 4'h0);
        check(route, 28'hFFFFFFD);
        check({nsteer, ncode, psteer, pcode}, 32'h0A85);
        while (stage !== 4'h1) @(posedge clk);
        check(route, 28'hFFFFFFE);
        check({nsteer, ncode, psteer, pcode}, 32'h937F);
        n = 0;
        while (stage === 4'h1) begin
            @(posedge clk);
            n++;
        end
        check(n, 384 * 80);
        check(stage, 4'h0);
        check(conv, 1'b1);
        touch <= 14'h0000;
        $display("test sequence done");
        wb(1'b0, 8'hC0, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, 8'hC4, 32'h0);
        check(rd, 32'h0000FF00);
        wb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h9);
        wb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h50);
        $display("test results done");
        wb(1'b1, 8'h00, 32'h00000106);
        while (conv !== 1'b0) @(posedge clk);
        t0 = cycles;
        wb(1'b0, 8'h04, 32'h0);
        check(rd[5:4], 2'h2);
        while (conv !== 1'b1) @(posedge clk);
        check(cycles - t0, 2 * STEP);
        $display("test low_power done");
        summarize;
    end
endmodule : tb_top
